/* File: hw/csie_cfg.svh */
/*
 * Register offsets, field positions and reset values for the clock-source
 * interrupt enable block. Assumes inclusion from the package and the design.
 */
`ifndef CSIE_CFG_SVH
`define CSIE_CFG_SVH
`define CSIE_OFS_CLEAR_VIEW   12'h000
`define CSIE_OFS_SET_VIEW     12'h004
`define CSIE_OFS_FLAG_REG     12'h008
`define CSIE_OFS_STATUS_REG   12'h00c
`define CSIE_OFS_REQ_REG      12'h010
`define CSIE_NUM_SRC          12
`define CSIE_ENABLE_RESET     12'h000
`define CSIE_FLAG_RESET       12'h000
`define CSIE_BIT_XOSC_RDY     0
`define CSIE_BIT_X32K_RDY     1
`define CSIE_BIT_I32K_RDY     2
`define CSIE_BIT_I8M_RDY      3
`define CSIE_BIT_FL_RDY       4
`define CSIE_BIT_FL_OOB       5
`define CSIE_BIT_FL_FINE      6
`define CSIE_BIT_FL_COARSE    7
`define CSIE_BIT_FL_REFSTOP   8
`define CSIE_BIT_SM_RDY       9
`define CSIE_BIT_SM_DET       10
`define CSIE_BIT_SM_SYNC      11
`endif

/* File: hw/csie_pkg.sv */
/*
 * Types shared by the clock-source interrupt enable block.
 * Assumes csie_cfg.svh on the include path.
 */
`include "csie_cfg.svh"
package csie_pkg;
    typedef logic [`CSIE_NUM_SRC-1:0] csie_src_t;
    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } csie_apb_req_t;
    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } csie_apb_rsp_t;
    typedef enum logic [1:0] {
        CSIE_IDLE   = 2'b00,
        CSIE_ACCESS = 2'b01
    } csie_state_t;
endpackage

/* File: hw/csie_flag_bank.sv */
/*
 * Per-source sticky interrupt flags, set on a rising status bit, cleared
 * by write-one. Assumes status inputs synchronous to clk.
 */
`include "csie_cfg.svh"
module csie_flag_bank (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    // Status and clear
    input  wire csie_pkg::csie_src_t  status,
    input  wire csie_pkg::csie_src_t  clearMask,
    // Flags
    output csie_pkg::csie_src_t       flags
);
    import csie_pkg::*;
    csie_src_t prevReg, prevNext, flagReg, flagNext;

    // ************************************************
    // Edge detect and sticky flags, one per source
    // ************************************************
    genvar i;
    for (i = 0; i < `CSIE_NUM_SRC; i++) begin : g_flag
        // Set wins over a simultaneous clear so no edge is lost
        always_comb begin
            prevNext[i] = status[i];
            flagNext[i] = (status[i] & ~prevReg[i]) | (flagReg[i] & ~clearMask[i]);
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            prevReg <= `CSIE_FLAG_RESET;
            flagReg <= `CSIE_FLAG_RESET;
        end else if (clkEn) begin
            prevReg <= prevNext;
            flagReg <= flagNext;
        end
    end
    assign flags = flagReg;

    a_flag_set_edge: assert property (@(posedge clk) disable iff (rst)
        clkEn && (status & ~prevReg) != '0 |=> (flagReg & $past(status & ~prevReg)) == $past(status & ~prevReg))
        else $error("flag missed a rising status bit");
endmodule

/* File: hw/csie_top.sv */
/*
 * Interrupt enable masking for twelve clock-source and supply-monitor
 * sources, with set and clear views of one shared enable state over APB.
 * Assumes a synchronous APB master on clk and status inputs on clk.
 */
// Decided for this implementation: the APB interface to the registers.
`include "csie_cfg.svh"
module csie_top (
    // Clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    clkEn,
    // APB slave
    input  wire csie_pkg::csie_apb_req_t apbReq,
    output csie_pkg::csie_apb_rsp_t      apbRsp,
    // Write guard and sources
    input  wire logic                    writeGuardActive,
    input  wire csie_pkg::csie_src_t     powerClockStatus,
    // Interrupt requests
    output csie_pkg::csie_src_t          irqRequest,
    output logic                         irqAny
);
    import csie_pkg::*;

    // ************************************************
    // APB access state
    // ************************************************
    csie_state_t stateReg, stateNext;
    csie_src_t   enableReg, enableNext;
    csie_src_t   reqReg, reqNext;
    logic [31:0] rdataReg, rdataNext;
    logic        errReg, errNext;
    csie_src_t   flagClear, flags;
    logic        setup, wrSet, wrClr, wrFlag, mapped;
    csie_src_t   wbits;

    // No wait state; read data is registered in the setup cycle
    assign setup  = apbReq.psel && !apbReq.penable;
    assign mapped = apbReq.paddr == `CSIE_OFS_CLEAR_VIEW || apbReq.paddr == `CSIE_OFS_SET_VIEW
                 || apbReq.paddr == `CSIE_OFS_FLAG_REG || apbReq.paddr == `CSIE_OFS_STATUS_REG
                 || apbReq.paddr == `CSIE_OFS_REQ_REG;
    // Upper data bits are dropped here
    assign wbits  = apbReq.pwdata[`CSIE_NUM_SRC-1:0];
    assign wrSet  = stateReg == CSIE_ACCESS && apbReq.pwrite && !writeGuardActive
                 && apbReq.paddr == `CSIE_OFS_SET_VIEW;
    assign wrClr  = stateReg == CSIE_ACCESS && apbReq.pwrite && !writeGuardActive
                 && apbReq.paddr == `CSIE_OFS_CLEAR_VIEW;
    assign wrFlag = stateReg == CSIE_ACCESS && apbReq.pwrite && apbReq.paddr == `CSIE_OFS_FLAG_REG;
    assign flagClear = wrFlag ? wbits : '0;

    // Next access state and read data
    always_comb begin
        stateNext = stateReg;
        rdataNext = rdataReg;
        errNext   = errReg;
        case (stateReg)
            CSIE_IDLE: begin
                if (setup) begin
                    stateNext = CSIE_ACCESS;
                    errNext   = !mapped || (apbReq.pwrite && writeGuardActive &&
                                (apbReq.paddr == `CSIE_OFS_SET_VIEW ||
                                 apbReq.paddr == `CSIE_OFS_CLEAR_VIEW));
                    rdataNext = 32'h0000_0000;
                    case (apbReq.paddr)
                        `CSIE_OFS_CLEAR_VIEW,
                        `CSIE_OFS_SET_VIEW:   rdataNext = {20'h0_0000, enableReg};
                        `CSIE_OFS_FLAG_REG:   rdataNext = {20'h0_0000, flags};
                        `CSIE_OFS_STATUS_REG: rdataNext = {20'h0_0000, powerClockStatus};
                        `CSIE_OFS_REQ_REG:    rdataNext = {20'h0_0000, reqReg};
                        default:              rdataNext = 32'h0000_0000;
                    endcase
                end
            end
            CSIE_ACCESS: begin
                stateNext = CSIE_IDLE;
            end
            default: begin
                stateNext = CSIE_IDLE;
            end
        endcase
    end

    // ************************************************
    // Shared enable state and request mask
    // ************************************************
    // Bit layout per source index comes from the cfg bit positions
    always_comb begin
        enableNext = enableReg;
        if (wrSet) begin
            enableNext = enableReg | wbits;
        end else if (wrClr) begin
            enableNext = enableReg & ~wbits;
        end
        reqNext = flags & enableReg;
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg  <= CSIE_IDLE;
            enableReg <= `CSIE_ENABLE_RESET;
            reqReg    <= '0;
            rdataReg  <= 32'h0000_0000;
            errReg    <= 1'b0;
        end else if (clkEn) begin
            stateReg  <= stateNext;
            enableReg <= enableNext;
            reqReg    <= reqNext;
            rdataReg  <= rdataNext;
            errReg    <= errNext;
        end
    end

    // Flag bank
    csie_flag_bank u_flags (
        .clk       (clk),
        .rst       (rst),
        .clkEn     (clkEn),
        .status    (powerClockStatus),
        .clearMask (flagClear),
        .flags     (flags)
    );

    // Outputs; pready stalls with the clock enable low
    assign apbRsp.pready  = stateReg == CSIE_ACCESS && clkEn;
    assign apbRsp.pslverr = stateReg == CSIE_ACCESS && errReg;
    assign apbRsp.prdata  = rdataReg;
    assign irqRequest     = reqReg;
    assign irqAny         = |reqReg;

    // ************************************************
    // Assertions
    // ************************************************
    a_req_follows_mask: assert property (@(posedge clk) disable iff (rst)
        clkEn |=> irqRequest == ($past(flags) & $past(enableReg)))
        else $error("request differs from flag and enable");
    a_no_req_disabled: assert property (@(posedge clk) disable iff (rst)
        clkEn && ~enableReg[`CSIE_BIT_FL_FINE] |=> !irqRequest[`CSIE_BIT_FL_FINE])
        else $error("request while disabled");
    a_clear_view_clears: assert property (@(posedge clk) disable iff (rst)
        clkEn && wrClr |=> (enableReg & $past(wbits)) == '0)
        else $error("clear view did not clear");
    a_set_view_sets: assert property (@(posedge clk) disable iff (rst)
        clkEn && wrSet |=> (enableReg & $past(wbits)) == $past(wbits))
        else $error("set view did not set");
    a_zero_bits_kept: assert property (@(posedge clk) disable iff (rst)
        clkEn && (wrSet || wrClr) |=> (enableReg & ~$past(wbits)) == ($past(enableReg) & ~$past(wbits)))
        else $error("unwritten enable bits changed");
    a_views_shared: assert property (@(posedge clk) disable iff (rst)
        apbRsp.pready && !apbReq.pwrite && (apbReq.paddr == `CSIE_OFS_SET_VIEW ||
        apbReq.paddr == `CSIE_OFS_CLEAR_VIEW) |-> apbRsp.prdata[11:0] == $past(enableReg))
        else $error("view read differs from enable state");
    a_upper_reads_zero: assert property (@(posedge clk) disable iff (rst)
        apbRsp.pready |-> apbRsp.prdata[31:12] == 20'h0_0000)
        else $error("upper read bits not zero");
    a_guard_blocks_write: assert property (@(posedge clk) disable iff (rst)
        clkEn && writeGuardActive && !wrFlag |=> enableReg == $past(enableReg))
        else $error("guarded write changed enable");
    a_fine_set_no_req: assert property (@(posedge clk) disable iff (rst)
        clkEn && wrSet && !flags[`CSIE_BIT_FL_FINE] |=> ##1
        !irqRequest[`CSIE_BIT_FL_FINE] || $past(flags[`CSIE_BIT_FL_FINE]))
        else $error("fine-lock set made a request");
    a_apb_one_wait: assert property (@(posedge clk) disable iff (rst)
        clkEn && setup && stateReg == CSIE_IDLE ##1 clkEn |-> apbRsp.pready)
        else $error("answer not after one wait");
    // Reset must leave every source disabled, whatever came before
    a_reset_all_off: assert property (@(posedge clk)
        $past(rst) |-> enableReg == `CSIE_ENABLE_RESET)
        else $error("enable state not zero after reset");
    // Low half of the layout: crystal ready sits at bit 0
    a_low_bit_place: assert property (@(posedge clk) disable iff (rst)
        clkEn && wrClr && wbits[0] |=> !enableReg[`CSIE_BIT_XOSC_RDY])
        else $error("crystal ready enable not at its bit");
    // High half of the layout: fine lock sits at bit 6
    a_high_bit_place: assert property (@(posedge clk) disable iff (rst)
        clkEn && wrSet && wbits[6] |=> enableReg[`CSIE_BIT_FL_FINE])
        else $error("fine lock enable not at its bit");
    // Every written one lands together one cycle later, others kept
    a_set_all_once: assert property (@(posedge clk) disable iff (rst)
        clkEn && wrSet |=> enableReg == ($past(enableReg) | $past(wbits)))
        else $error("set write not applied in one cycle");
    // A frozen clock enable must hold the whole enable state
    a_freeze_holds: assert property (@(posedge clk) disable iff (rst)
        !clkEn |=> enableReg == $past(enableReg) && irqRequest == $past(irqRequest))
        else $error("state moved while clock enable low");

    c_set_write:  cover property (@(posedge clk) disable iff (rst) clkEn && wrSet);
    c_clear_write: cover property (@(posedge clk) disable iff (rst) clkEn && wrClr);
    c_irq_raised: cover property (@(posedge clk) disable iff (rst) irqAny);
    c_guard_err:  cover property (@(posedge clk) disable iff (rst) apbRsp.pready && apbRsp.pslverr);
    c_frozen:     cover property (@(posedge clk) disable iff (rst) !clkEn && |powerClockStatus);
endmodule

/* File: tb/tb_csie_top.sv */
/*
 * Self-checking bench for csie_top: enable views, write guard, unmapped
 * access and request masking; registers are reached through APB tasks, status and clock enable driven directly.
 * Assumes the hw/ files compiled first and csie_cfg.svh on the include path.
 */
`include "csie_cfg.svh"
module tb_csie_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csie_pkg::*;

    // ********************
    // Signals and design
    // ********************
    logic          clk;
    logic          rst;
    logic          clkEn;
    csie_apb_req_t apbReq;
    csie_apb_rsp_t apbRsp;
    logic          writeGuardActive;
    csie_src_t     powerClockStatus;
    csie_src_t     irqRequest;
    logic          irqAny;
    int            errors;
    int            numChecks;
    logic [31:0]   rd;
    logic          err;
    logic [31:0]   expEn;

    csie_top uut (
        .clk              (clk),
        .rst              (rst),
        .clkEn            (clkEn),
        .apbReq           (apbReq),
        .apbRsp           (apbRsp),
        .writeGuardActive (writeGuardActive),
        .powerClockStatus (powerClockStatus),
        .irqRequest       (irqRequest),
        .irqAny           (irqAny)
    );

    // ********************
    // Tasks
    // ********************
    // Verdict, reached from the main sequence or a timeout
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chkReg(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Requests and their OR, sampled at a settled falling edge
    task automatic chkIrq(input csie_src_t exp);
        numChecks++;
        if (irqRequest !== exp || irqAny !== (|exp)) begin
            errors++;
            $display("[ERR] irqRequest expected %h seen %h any %b", exp, irqRequest, irqAny);
        end
    endtask

    // One APB transfer; answer read at the falling edge before the sampling edge, stable across it
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge clk);
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= wr;
        apbReq.paddr   <= addr;
        apbReq.pwdata  <= wdata;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            if (apbRsp.pready === 1'b1) break;
        end
        if (n == 50) begin
            errors++;
            stop_test();
        end
        rd  = apbRsp.prdata;
        err = apbRsp.pslverr;
        @(posedge clk);
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
        apb(1'b0, addr, 32'h0);
        chkReg("prdata", exp, rd);
        chkReg("pslverr", {31'h0, expErr}, {31'h0, err});
    endtask

    // ********************
    // Clock and sequence
    // ********************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        errors = 0;
        numChecks = 0;
        rst = 1'b1;
        clkEn = 1'b1;
        apbReq = '0;
        writeGuardActive = 1'b0;
        powerClockStatus = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdChk(`CSIE_OFS_SET_VIEW, 32'h0, 1'b0);
        rdChk(`CSIE_OFS_CLEAR_VIEW, 32'h0, 1'b0);
        $display("test reset done");
        // Set one bit at a time, read back through the other view
        expEn = '0;
        for (int i = 0; i < `CSIE_NUM_SRC; i++) begin
            expEn[i] = 1'b1;
            apb(1'b1, `CSIE_OFS_SET_VIEW, 32'h1 << i);
            rdChk(`CSIE_OFS_CLEAR_VIEW, expEn, 1'b0);
        end
        apb(1'b1, `CSIE_OFS_SET_VIEW, 32'h0);
        apb(1'b1, `CSIE_OFS_CLEAR_VIEW, 32'h0);
        rdChk(`CSIE_OFS_SET_VIEW, 32'hfff, 1'b0);
        for (int i = 0; i < `CSIE_NUM_SRC; i++) begin
            expEn[i] = 1'b0;
            apb(1'b1, `CSIE_OFS_CLEAR_VIEW, 32'h1 << i);
            rdChk(`CSIE_OFS_SET_VIEW, expEn, 1'b0);
        end
        $display("test views done");
        // Several bits move in one set write and in one clear write
        apb(1'b1, `CSIE_OFS_SET_VIEW, 32'h0000_00a5);
        rdChk(`CSIE_OFS_SET_VIEW, 32'h0a5, 1'b0);
        apb(1'b1, `CSIE_OFS_CLEAR_VIEW, 32'h21);
        rdChk(`CSIE_OFS_CLEAR_VIEW, 32'h084, 1'b0);
        writeGuardActive <= 1'b1;
        apb(1'b1, `CSIE_OFS_SET_VIEW, 32'hfff);
        chkReg("guard pslverr", 32'h1, {31'h0, err});
        writeGuardActive <= 1'b0;
        rdChk(`CSIE_OFS_SET_VIEW, 32'h084, 1'b0);
        rdChk(12'h020, 32'h0, 1'b1);
        apb(1'b1, `CSIE_OFS_CLEAR_VIEW, 32'hfff);
        $display("test guard done");
        // All flags raised, only one source enabled
        apb(1'b1, `CSIE_OFS_SET_VIEW, 32'h1 << `CSIE_BIT_I8M_RDY);
        powerClockStatus <= 12'hfff;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chkIrq(12'h008);
        rdChk(`CSIE_OFS_FLAG_REG, 32'hfff, 1'b0);
        apb(1'b1, `CSIE_OFS_CLEAR_VIEW, 32'h1 << `CSIE_BIT_I8M_RDY);
        repeat (2) @(negedge clk);
        chkIrq(12'h000);
        apb(1'b1, `CSIE_OFS_FLAG_REG, 32'hfff);
        rdChk(`CSIE_OFS_FLAG_REG, 32'h0, 1'b0);
        // Fine-lock enable alone must not create a request
        apb(1'b1, `CSIE_OFS_SET_VIEW, 32'h1 << `CSIE_BIT_FL_FINE);
        repeat (2) @(negedge clk);
        chkIrq(12'h000);
        @(posedge clk);
        powerClockStatus <= 12'h000;
        @(posedge clk);
        powerClockStatus <= 12'h040;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chkIrq(12'h040);
        $display("test requests done");
        // Frozen clock enable: a rise on bit 0 in that time is never seen
        clkEn <= 1'b0;
        @(posedge clk);
        powerClockStatus <= 12'h041;
        repeat (2) @(posedge clk);
        powerClockStatus <= 12'h040;
        @(posedge clk);
        clkEn <= 1'b1;
        repeat (2) @(negedge clk);
        chkIrq(12'h040);
        rdChk(`CSIE_OFS_FLAG_REG, 32'h040, 1'b0);
        $display("test freeze done");
        stop_test();
    end
endmodule
